// >>> inc/ulpirb_pkg.sv
// Purpose: Constants and types for the ULPI transceiver register bank.
// Assumes: 6-bit register addresses, 8-bit registers, 250 MHz interface clock.
// Notes:   Identity values are parameters of the top module.
package ulpirb_pkg;

    // ------------------------------------------------------------------
    // Register addresses
    // ------------------------------------------------------------------
    localparam logic [5:0] MAKER_CODE_LO_ADDR    = 6'h00;
    localparam logic [5:0] MAKER_CODE_HI_ADDR    = 6'h01;
    localparam logic [5:0] PART_NUMBER_LO_ADDR   = 6'h02;
    localparam logic [5:0] PART_NUMBER_HI_ADDR   = 6'h03;
    localparam logic [5:0] TRANSCEIVER_FUNCTION_CONTROL_ADDR        = 6'h04;
    localparam logic [5:0] ALT_ALT_INTERFACE_CONTROL_ADDR    = 6'h07;
    localparam logic [5:0] DUAL_ROLE_CTRL_ADDR   = 6'h0a;
    localparam logic [5:0] RISE_IRQ_EN_ADDR      = 6'h0d;
    localparam logic [5:0] FALL_IRQ_EN_ADDR      = 6'h10;
    localparam logic [5:0] IRQ_STATUS_NOW_ADDR   = 6'h13;
    localparam logic [5:0] IRQ_LATCHED_ADDR      = 6'h14;
    localparam logic [5:0] LINE_DEBUG_VIEW_ADDR  = 6'h15;
    localparam logic [5:0] SPARE_STORAGE_ADDR    = 6'h16;
    localparam logic [5:0] CAR_ACC_CTRL_ADDR     = 6'h19;
    localparam logic [5:0] RESERVED_FIRST_ADDR   = 6'h1c;
    localparam logic [5:0] POWER_CONTROL_ADDR    = 6'h3d;

    // Writable register groups, each owning base, base+1 (set), base+2 (clear).
    localparam int         NUM_GROUPS            = 8;
    localparam logic [NUM_GROUPS*6-1:0] GROUP_BASES = {
        POWER_CONTROL_ADDR, CAR_ACC_CTRL_ADDR, SPARE_STORAGE_ADDR, FALL_IRQ_EN_ADDR,
        RISE_IRQ_EN_ADDR, DUAL_ROLE_CTRL_ADDR, ALT_ALT_INTERFACE_CONTROL_ADDR, TRANSCEIVER_FUNCTION_CONTROL_ADDR};
    localparam logic [2:0] TRANSCEIVER_FUNCTION_CONTROL_GROUP       = 3'd0;

    // ------------------------------------------------------------------
    // Function control fields and reset values
    // ------------------------------------------------------------------
    localparam int         FC_RESERVED_BIT       = 7;
    localparam int         FC_LOW_POWER_N_BIT    = 6;
    localparam int         FC_CORE_RESET_BIT     = 5;
    localparam logic [7:0] TRANSCEIVER_FUNCTION_CONTROL_RESET       = 8'h41;
    localparam logic [7:0] OTHER_CTRL_RESET      = 8'h00;
    localparam logic [7:0] TRANSCEIVER_FUNCTION_CONTROL_WMASK       = 8'h7f;

    // ------------------------------------------------------------------
    // Bus commands and timing
    // ------------------------------------------------------------------
    localparam logic [1:0] CMD_REG_WRITE         = 2'b10;
    localparam logic [1:0] CMD_REG_READ          = 2'b11;
    localparam int         CLK_PERIOD_PS         = 4000;
    localparam int         CORE_RESET_NS         = 100;
    localparam int         CORE_RESET_CYCLES     = (CORE_RESET_NS * 1000 + CLK_PERIOD_PS - 1)
                                                   / CLK_PERIOD_PS;

    // ------------------------------------------------------------------
    // Types
    // ------------------------------------------------------------------
    typedef enum logic [1:0] {STYLE_READ, STYLE_WRITE, STYLE_SET, STYLE_CLEAR} ulpirb_style_t;

    typedef struct packed {
        logic          writable;
        logic [2:0]    group;
        ulpirb_style_t style;
    } ulpirb_decode_t;

endpackage : ulpirb_pkg

// >>> verilog/ulpirb_bank.sv
// Purpose: Register bank of a ULPI transceiver, reached by the link over the ULPI bus.
// Assumes: All inputs synchronous to clock_in; link follows ULPI register access timing.
// Notes:   Holds core reset and low-power control; other fields are plain storage.
//
// What this block does
// - Decode 6-bit addresses; writable registers have read, write, set, clear addresses.
// - Read-only registers ignore every write.
// - Write address replaces the register with the bus byte; function control bit 7 stays zero.
// - Set address ORs the bus byte into the register.
// - Clear address zeroes each bit whose mask bit is one.
// - Maker code is 16 bits, fixed low and high bytes, read-only.
// - Part number is 16 bits at the next two addresses, read-only.
// - Function control readable at all three addresses; written, set, cleared at one each.
// - Bit 6 active-low suspend: zero enters low power, one stays powered.
// - Low power shuts all blocks but full-speed receiver, comparators, interface pins.
// - Link asserts stop to leave low power; device updates suspend bit itself.
// - Setting core reset bit raises DIR and resets core; registers keep state.
// - After core reset, drop DIR, clear reset bit, then send receive-command.
// - Device enables data drivers only one clock after raising DIR.
`timescale 1ns/1ps

module ulpirb_bank
    import ulpirb_pkg::*;
#(
    parameter logic [15:0] MAKER_CODE  = 16'h5a3c,  // Arbitrary value.
    parameter logic [15:0] PART_NUMBER = 16'h00a1   // Arbitrary value.
)(
    // Clock and reset
    input  wire logic       clock_in,
    input  wire logic       rst_b_in,
    // ULPI bus
    input  wire logic       stp_in,
    input  wire logic [7:0] data_in,
    output logic [7:0]      data_out,
    output logic            data_oe_out,
    output logic            dir_out,
    output logic            nxt_out,
    // Transceiver status sources
    input  wire logic [7:0] rx_status_in,
    input  wire logic [7:0] irq_status_now_in,
    input  wire logic [7:0] irq_latched_in,
    input  wire logic [7:0] line_debug_view_in,
    // Transceiver controls
    output logic            phy_low_power_n_out,
    output logic            core_reset_out,
    output logic [7:0]      transceiver_function_control_out
);

    // ------------------------------------------------------------------
    // Address decode
    // ------------------------------------------------------------------
    function automatic ulpirb_decode_t decode(input logic [5:0] addr);
        ulpirb_decode_t d;
        logic [5:0]     base;
        d = '{writable: 1'b0, group: 3'd0, style: STYLE_READ};
        for (int g = 0; g < NUM_GROUPS; g++)
        begin
            base = GROUP_BASES[g*6 +: 6];
            if (addr >= base && addr <= base + 6'd2)
            begin
                d.writable = 1'b1;
                d.group    = 3'(g);
                d.style    = ulpirb_style_t'(2'(addr - base) + 2'd1);
            end
        end
        return d;
    endfunction : decode

    typedef enum logic [3:0] {
        ST_IDLE, ST_WR_CMD, ST_WR_DATA, ST_WR_STP, ST_RD_CMD, ST_RD_TURN, ST_RD_DATA,
        ST_CORE_RST, ST_RX_GAP, ST_RX_TURN, ST_RX_DATA
    } ulpirb_state_t;

    ulpirb_state_t  state_q;
    logic [5:0]     addr_q;
    logic [7:0]     wdata_q;
    logic [7:0]     ctrl_q [NUM_GROUPS];
    logic [15:0]    rst_cnt_q;
    logic [7:0]     data_q;
    logic           data_oe_q;
    logic           dir_q;
    logic           nxt_q;
    ulpirb_decode_t wr_dec;
    logic           commit;
    logic           core_done;
    logic           wake;
    logic           in_low_power;
    logic           in_core_reset;
    logic [7:0]     rd_value;
    ulpirb_decode_t rd_dec;

    assign in_low_power  = ~ctrl_q[TRANSCEIVER_FUNCTION_CONTROL_GROUP][FC_LOW_POWER_N_BIT];
    assign in_core_reset = ctrl_q[TRANSCEIVER_FUNCTION_CONTROL_GROUP][FC_CORE_RESET_BIT];
    assign wr_dec        = decode(addr_q);
    assign rd_dec        = decode(addr_q);
    assign commit        = (state_q == ST_WR_STP) && stp_in;
    assign core_done     = (state_q == ST_CORE_RST) && (rst_cnt_q == 16'(CORE_RESET_CYCLES - 1));
    assign wake          = (state_q == ST_IDLE) && in_low_power && stp_in;

    // ------------------------------------------------------------------
    // Read multiplexer
    // ------------------------------------------------------------------
    always_comb
    begin
        rd_value = 8'h00;
        unique case (addr_q)
            MAKER_CODE_LO_ADDR:   rd_value = MAKER_CODE[7:0];
            MAKER_CODE_HI_ADDR:   rd_value = MAKER_CODE[15:8];
            PART_NUMBER_LO_ADDR:  rd_value = PART_NUMBER[7:0];
            PART_NUMBER_HI_ADDR:  rd_value = PART_NUMBER[15:8];
            IRQ_STATUS_NOW_ADDR:  rd_value = irq_status_now_in;
            IRQ_LATCHED_ADDR:     rd_value = irq_latched_in;
            LINE_DEBUG_VIEW_ADDR: rd_value = line_debug_view_in;
            default:
            begin
                if (rd_dec.writable)
                begin
                    rd_value = ctrl_q[rd_dec.group];
                end
            end
        endcase
    end

    // ------------------------------------------------------------------
    // Register storage
    // ------------------------------------------------------------------
    generate
        for (genvar g = 0; g < NUM_GROUPS; g++)
        begin : g_ctrl
            localparam logic [7:0] RST_VAL = (g == 0) ? TRANSCEIVER_FUNCTION_CONTROL_RESET : OTHER_CTRL_RESET;
            localparam logic [7:0] WMASK   = (g == 0) ? TRANSCEIVER_FUNCTION_CONTROL_WMASK : 8'hff;
            logic [7:0] ctrl_d;

            always_comb
            begin
                ctrl_d = ctrl_q[g];
                if (commit && wr_dec.writable && wr_dec.group == 3'(g))
                begin
                    unique case (wr_dec.style)
                        STYLE_WRITE: ctrl_d = wdata_q;
                        STYLE_SET:   ctrl_d = ctrl_q[g] | wdata_q;
                        STYLE_CLEAR: ctrl_d = ctrl_q[g] & ~wdata_q;
                        STYLE_READ:  ctrl_d = ctrl_q[g];
                    endcase
                end
                if (g == 0 && core_done)
                begin
                    ctrl_d[FC_CORE_RESET_BIT] = 1'b0;
                end
                if (g == 0 && wake)
                begin
                    ctrl_d[FC_LOW_POWER_N_BIT] = 1'b1;
                end
                ctrl_d = ctrl_d & WMASK;
            end

            // Core reset only clears its own bit in group 0 when it ends; only rst_b_in reloads reset values.
            always_ff @(posedge clock_in)
            begin
                if (!rst_b_in)
                begin
                    ctrl_q[g] <= RST_VAL;
                end
                else
                begin
                    ctrl_q[g] <= ctrl_d;
                end
            end
        end
    endgenerate

    // ------------------------------------------------------------------
    // Core reset timer
    // ------------------------------------------------------------------
    // Held at zero outside the core reset, so every core reset starts a fresh count.
    always_ff @(posedge clock_in)
    begin
        if (!rst_b_in || state_q != ST_CORE_RST)
        begin
            rst_cnt_q <= 16'h0000;
        end
        else
        begin
            rst_cnt_q <= rst_cnt_q + 16'h0001;
        end
    end

    // ------------------------------------------------------------------
    // Bus sequencer
    // ------------------------------------------------------------------
    always_ff @(posedge clock_in)
    begin
        if (!rst_b_in)
        begin
            state_q   <= ST_IDLE;
            addr_q    <= 6'h00;
            wdata_q   <= 8'h00;
            data_q    <= 8'h00;
            data_oe_q <= 1'b0;
            dir_q     <= 1'b0;
            nxt_q     <= 1'b0;
        end
        else
        begin
            unique case (state_q)
                ST_IDLE:
                begin
                    if (in_core_reset)
                    begin
                        dir_q     <= 1'b1;
                        state_q   <= ST_CORE_RST;
                    end
                    else if (!in_low_power && data_in[7:6] == CMD_REG_WRITE)
                    begin
                        addr_q  <= data_in[5:0];
                        nxt_q   <= 1'b1;
                        state_q <= ST_WR_CMD;
                    end
                    else if (!in_low_power && data_in[7:6] == CMD_REG_READ)
                    begin
                        addr_q  <= data_in[5:0];
                        nxt_q   <= 1'b1;
                        state_q <= ST_RD_CMD;
                    end
                end
                ST_WR_CMD:
                begin
                    state_q <= ST_WR_DATA;
                end
                ST_WR_DATA:
                begin
                    wdata_q <= data_in;
                    nxt_q   <= 1'b0;
                    state_q <= ST_WR_STP;
                end
                ST_WR_STP:
                begin
                    if (stp_in)
                    begin
                        state_q <= ST_IDLE;
                    end
                end
                ST_RD_CMD:
                begin
                    nxt_q   <= 1'b0;
                    dir_q   <= 1'b1;
                    state_q <= ST_RD_TURN;
                end
                ST_RD_TURN:
                begin
                    data_oe_q <= 1'b1;
                    data_q    <= rd_value;
                    state_q   <= ST_RD_DATA;
                end
                ST_RD_DATA:
                begin
                    data_oe_q <= 1'b0;
                    dir_q     <= 1'b0;
                    data_q    <= 8'h00;
                    state_q   <= ST_IDLE;
                end
                ST_CORE_RST:
                begin
                    if (core_done)
                    begin
                        dir_q   <= 1'b0;
                        state_q <= ST_RX_GAP;
                    end
                end
                ST_RX_GAP:
                begin
                    dir_q   <= 1'b1;
                    state_q <= ST_RX_TURN;
                end
                ST_RX_TURN:
                begin
                    data_oe_q <= 1'b1;
                    data_q    <= rx_status_in;
                    state_q   <= ST_RX_DATA;
                end
                ST_RX_DATA:
                begin
                    data_oe_q <= 1'b0;
                    dir_q     <= 1'b0;
                    data_q    <= 8'h00;
                    state_q   <= ST_IDLE;
                end
            endcase
        end
    end

    // ------------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------------
    assign data_out                         = data_q;
    assign data_oe_out                      = data_oe_q;
    assign dir_out                          = dir_q;
    assign nxt_out                          = nxt_q;
    assign phy_low_power_n_out              = ctrl_q[TRANSCEIVER_FUNCTION_CONTROL_GROUP][FC_LOW_POWER_N_BIT];
    assign core_reset_out                   = ctrl_q[TRANSCEIVER_FUNCTION_CONTROL_GROUP][FC_CORE_RESET_BIT];
    assign transceiver_function_control_out = ctrl_q[TRANSCEIVER_FUNCTION_CONTROL_GROUP];

endmodule : ulpirb_bank

// >>> verification/ulpirb_chk.sv
// Purpose: Assertions on the bank's ULPI and control ports.
// Assumes: One clock, synchronous active-low reset.
// Notes:   Bound to every instance of the bank.
`timescale 1ns/1ps
module ulpirb_chk (
    // Clock and reset
    input wire logic       clock_in,
    input wire logic       rst_b_in,
    // ULPI bus
    input wire logic       stp_in,
    input wire logic [7:0] data_out,
    input wire logic       data_oe_out,
    input wire logic       dir_out,
    input wire logic       nxt_out,
    // Controls
    input wire logic       phy_low_power_n_out,
    input wire logic       core_reset_out,
    input wire logic [7:0] transceiver_function_control_out
);
    default clocking cb @(posedge clock_in); endclocking
    default disable iff (!rst_b_in);

    chk_oe_needs_dir: assert property (data_oe_out |-> dir_out)
        else $error("data driven without owning the bus");
    chk_turn_around: assert property ($rose(dir_out) |-> !data_oe_out)
        else $error("drivers on in the turnaround cycle");
    chk_oe_delayed: assert property ($rose(data_oe_out) |-> $past(dir_out))
        else $error("drivers on before the bus was taken");
    chk_rsvd_zero: assert property (!transceiver_function_control_out[7])
        else $error("reserved control bit set");
    chk_fields_track: assert property (phy_low_power_n_out == transceiver_function_control_out[6]
        && core_reset_out == transceiver_function_control_out[5])
        else $error("control pins differ from register");
    chk_reset_owns: assert property (core_reset_out && $past(core_reset_out, 2) |-> dir_out)
        else $error("bus released during core reset");
    chk_reset_release: assert property ($fell(core_reset_out) && $past(rst_b_in)
        |-> !dir_out ##[1:2] dir_out)
        else $error("no status update after core reset");
    chk_quiet_sleep: assert property (!phy_low_power_n_out && !$past(phy_low_power_n_out)
        |-> !nxt_out)
        else $error("command taken in low power");
    chk_wake_up: assert property (stp_in && !phy_low_power_n_out
        |-> ##[1:2] phy_low_power_n_out)
        else $error("stop did not end low power");

    cover property ($rose(core_reset_out));
    cover property ($fell(phy_low_power_n_out));
    cover property ($rose(data_oe_out));
endmodule : ulpirb_chk

bind ulpirb_bank ulpirb_chk ulpirb_chk_i (.clock_in(clock_in), .rst_b_in(rst_b_in),
    .stp_in(stp_in), .data_out(data_out), .data_oe_out(data_oe_out), .dir_out(dir_out),
    .nxt_out(nxt_out), .phy_low_power_n_out(phy_low_power_n_out),
    .core_reset_out(core_reset_out),
    .transceiver_function_control_out(transceiver_function_control_out));

// >>> verification/ulpirb_link_model.sv
// Purpose: Link controller model on the bank's ULPI side.
// Assumes: Drives on falling edges; tasks are called by the bench.
// Notes:   A released bus shows the inverse of the last link byte.
`timescale 1ns/1ps
module ulpirb_link_model (
    // Clock
    input  wire logic       clock_in,
    // Bank side
    input  wire logic       dir_in,
    input  wire logic       nxt_in,
    input  wire logic       oe_in,
    input  wire logic [7:0] phy_data_in,
    output logic            stp_out,
    output logic [7:0]      data_out
);
    logic [7:0] drv = 8'h00;

    initial stp_out = 1'b0;
    assign data_out = dir_in ? (oe_in ? phy_data_in : ~drv) : drv;

    task automatic cmd(input logic [7:0] c, output logic ok);
        int i;
        i = 0;
        @(negedge clock_in);
        drv = c;
        do @(negedge clock_in); while (!nxt_in && i++ < 6);
        ok = nxt_in;
        if (!ok)
            drv = 8'h00;
    endtask : cmd

    task automatic wr(input logic [5:0] a, input logic [7:0] v, output logic ok);
        cmd({2'b10, a}, ok);
        if (ok)
        begin
            @(negedge clock_in);
            drv = v;
            @(negedge clock_in);
            drv = 8'h00;
            stp_out = 1'b1;
            @(negedge clock_in);
            stp_out = 1'b0;
        end
    endtask : wr

    task automatic rd(input logic [5:0] a, output logic [7:0] v, output logic ok);
        int i;
        i = 0;
        cmd({2'b11, a}, ok);
        do @(negedge clock_in); while (!oe_in && i++ < 6);
        drv = 8'h00;
        v = phy_data_in;
        ok = oe_in;
        @(negedge clock_in);
    endtask : rd

    task automatic wake;
        @(negedge clock_in);
        stp_out = 1'b1;
        @(negedge clock_in);
        stp_out = 1'b0;
        @(negedge clock_in);
    endtask : wake
endmodule : ulpirb_link_model

// >>> verification/ulpi_phy_register_bank_bench.sv
// Purpose: Self-checking bench for the ULPI register bank.
// Assumes: Link model drives the bus; status inputs are fixed bytes.
// Notes:   Identity values are arbitrary.
`timescale 1ns/1ps
module ulpi_phy_register_bank_bench;
    import ulpirb_pkg::*;
    localparam logic [15:0] MC = 16'h1e2d; // Arbitrary value.
    localparam logic [15:0] PN = 16'h0b73; // Arbitrary value.
    logic       clock_in, rst_b_in, stp, dir, nxt, oe, lp_n, crst;
    logic [7:0] d_in, d_out, fc;
    logic [7:0] rx = 8'hc4, irq_now = 8'h93, irq_l = 8'h3e, dbg = 8'h6b;
    int         n_fail = 0, checks = 0, cyc = 0;

    ulpirb_bank #(.MAKER_CODE(MC), .PART_NUMBER(PN)) ulpirb_bank_i (.clock_in(clock_in),
        .rst_b_in(rst_b_in), .stp_in(stp), .data_in(d_in), .data_out(d_out),
        .data_oe_out(oe), .dir_out(dir), .nxt_out(nxt), .rx_status_in(rx),
        .irq_status_now_in(irq_now), .irq_latched_in(irq_l), .line_debug_view_in(dbg),
        .phy_low_power_n_out(lp_n), .core_reset_out(crst),
        .transceiver_function_control_out(fc));
    ulpirb_link_model ulpirb_link_model_i (.clock_in(clock_in), .dir_in(dir), .nxt_in(nxt),
        .oe_in(oe), .phy_data_in(d_out), .stp_out(stp), .data_out(d_in));

    task automatic cmp(input string nm, input logic [7:0] e, input logic [7:0] g);
        checks++;
        if (g !== e)
        begin
            n_fail++;
            $display("[ERR] %s expected %h seen %h", nm, e, g);
        end
    endtask : cmp

    task automatic rd_chk(input string nm, input logic [5:0] a, input logic [7:0] e);
        logic [7:0] v;
        logic       ok;
        ulpirb_link_model_i.rd(a, v, ok);
        cmp(nm, e, v);
    endtask : rd_chk

    task automatic t_reset;
        cmp("control after reset", 8'h41, fc);
        for (int a = 4; a < 7; a++)
            rd_chk("control read", 6'(a), 8'h41);
        $display("t_reset done");
    endtask : t_reset

    task automatic t_fixed;
        logic [5:0] a[9] = '{6'h00, 6'h01, 6'h02, 6'h03, 6'h13, 6'h14, 6'h15, 6'h1c, 6'h3c};
        logic [7:0] e[9] = '{MC[7:0], MC[15:8], PN[7:0], PN[15:8], irq_now, irq_l, dbg,
                             8'h00, 8'h00};
        logic       ok;
        for (int i = 0; i < 9; i++)
        begin
            ulpirb_link_model_i.wr(a[i], 8'hff, ok);
            rd_chk("read only", a[i], e[i]);
        end
        $display("t_fixed done");
    endtask : t_fixed

    task automatic t_styles;
        logic [5:0] b;
        logic       ok;
        for (int g = 0; g < NUM_GROUPS; g++)
        begin
            b = GROUP_BASES[g*6 +: 6];
            ulpirb_link_model_i.wr(b, {2'b01, b}, ok);
            rd_chk("group write", b + 6'd2, {2'b01, b});
        end
        ulpirb_link_model_i.wr(6'h17, 8'ha1, ok);
        rd_chk("set", 6'h16, 8'hf7);
        ulpirb_link_model_i.wr(6'h18, 8'h35, ok);
        rd_chk("clear", 6'h16, 8'hc2);
        ulpirb_link_model_i.wr(6'h04, 8'hc1, ok);
        rd_chk("control write", 6'h05, 8'h41);
        $display("t_styles done");
    endtask : t_styles

    task automatic t_sleep;
        logic ok;
        ulpirb_link_model_i.wr(6'h06, 8'h40, ok);
        cmp("low power pin", 8'h00, {7'h0, lp_n});
        ulpirb_link_model_i.cmd({2'b10, 6'h16}, ok);
        cmp("refused command", 8'h00, {7'h0, ok});
        ulpirb_link_model_i.wake();
        cmp("wake pin", 8'h01, {7'h0, lp_n});
        rd_chk("control after wake", 6'h04, 8'h41);
        $display("t_sleep done");
    endtask : t_sleep

    task automatic t_core;
        int   n;
        logic ok;
        ulpirb_link_model_i.wr(6'h05, 8'h26, ok);
        n = 0;
        while (!dir && n++ < 8) @(negedge clock_in);
        cmp("core reset pin", 8'h01, {7'h0, crst});
        n = 0;
        while (dir && n < 100)
        begin
            @(negedge clock_in);
            n++;
        end
        cmp("reset length", 8'(CORE_RESET_CYCLES), n[7:0]);
        cmp("reset bit cleared", 8'h00, {7'h0, crst});
        n = 0;
        while (!oe && n++ < 8) @(negedge clock_in);
        cmp("status byte", rx, d_out);
        n = 0;
        while (dir && n++ < 8) @(negedge clock_in);
        rd_chk("control kept", 6'h04, 8'h47);
        $display("t_core done");
    endtask : t_core

    task automatic close_out;
        $display("checks %0d n_fail %0d", checks, n_fail);
        if (n_fail == 0 && checks > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask : close_out

    initial
    begin
        clock_in = 1'b0;
        forever #2 clock_in = ~clock_in;
    end

    always @(posedge clock_in)
    begin
        cyc++;
        if (cyc == 3000)
        begin
            n_fail++;
            close_out();
        end
    end

    initial
    begin
        rst_b_in = 1'b0;
        repeat (4) @(posedge clock_in);
        @(negedge clock_in);
        rst_b_in = 1'b1;
        t_reset();
        t_fixed();
        t_styles();
        t_sleep();
        t_core();
        close_out();
    end
endmodule : ulpi_phy_register_bank_bench
